/* File: rtl/host_xfer_cfg.svh */
`ifndef HOST_XFER_CFG_SVH
`define HOST_XFER_CFG_SVH
// Register offsets on the parallel port
`define CTRL_A_ADDR      8'h00
`define CTRL_B_ADDR      8'h08
`define CTRL1_ADDR       8'h05
`define CTRL2_ADDR       8'h0f
// Control register field positions
`define BIT_PREAMBLE     7
`define BIT_TOGGLE       6
`define BIT_ALIGN        5
`define BIT_ISO          4
`define BIT_RESERVED     3
`define BIT_DIR          2
`define BIT_ENABLE       1
`define BIT_GO           0
// Speed and polarity bits in the other control registers
`define BIT_LOW_SPEED    5
`define BIT_LS_POLARITY  6
// Reset values
`define CTRL_RESET       8'h00
`define CTRL1_RESET      8'h00
`define CTRL2_RESET      8'h00
`endif

/* File: rtl/host_xfer_pkg.sv */
package host_xfer_pkg;
  // Scheduler state
  typedef enum logic [1:0] {
    SCH_IDLE,
    SCH_WAIT_SOF,
    SCH_LAUNCH,
    SCH_BUSY
  } sched_state_t;
  // Launch request descriptor kinds
  typedef enum logic [1:0] {
    PKT_IN,
    PKT_OUT_DATA0,
    PKT_OUT_DATA1
  } pkt_kind_t;
endpackage : host_xfer_pkg

/* File: rtl/xfer_ctrl_set.sv */
`timescale 1ns/1ps
`include "host_xfer_cfg.svh"
// One control register set (A or B) with self-clearing go bit
module xfer_ctrl_set #(
  parameter logic [7:0] ADDR = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       done,
  output logic      [7:0] ctrl
);
  logic [7:0] ctrl_reg;   // Stored control byte
  logic [7:0] ctrl_next;  // Next control byte

  ////////////////////////////////////////////////////////////////////////////
  // Next value: a write stores the byte, completion drops go
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_en && (addr == ADDR)) begin
      ctrl_next = wdata;
      // Reserved bit holds no state
      ctrl_next[`BIT_RESERVED] = 1'b0;
    end
    // Completion wins over a same-cycle write of go, so a stale
    // write cannot relaunch a transfer that just ended
    if (done) begin
      ctrl_next[`BIT_GO] = 1'b0;
    end
  end

  // Register; all bits reset to zero, go among them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctrl = ctrl_reg;
endmodule : xfer_ctrl_set

/* File: rtl/usb_host_transfer_control.sv */
`timescale 1ns/1ps
`include "host_xfer_cfg.svh"
// Transfer control for both register sets, and the launch scheduler
module usb_host_transfer_control (
  input  wire logic       clk,            // 10 MHz system clock
  input  wire logic       sys_rst,        // Asynchronous reset, active high
  input  wire logic       wr_en,          // Parallel port write strobe
  input  wire logic       rd_en,          // Parallel port read strobe
  input  wire logic [7:0] addr,           // Register address
  input  wire logic [7:0] wdata,          // Write data
  output logic      [7:0] rdata,          // Read data, registered
  input  wire logic       sof_sent,       // Pulse: engine finished an SOF
  input  wire logic       engine_busy,    // Serial engine occupied
  input  wire logic       xfer_complete,  // Pulse: launched transfer ended
  output logic            launch,         // Pulse: start a packet
  output logic            launch_set_b,   // Set that was launched
  output logic            send_preamble,  // Precede packet by preamble
  output logic            dir_out,        // 1 OUT, 0 IN
  output logic            data_toggle,    // DATA1 when 1, OUT only
  output logic            iso_mode,       // Isochronous packet
  output logic            done_a,         // Pulse: done interrupt, set A
  output logic            done_b,         // Pulse: done interrupt, set B
  output logic            ext_mode        // Extended feature mode on
);
  ////////////////////////////////////////////////////////////////////////////
  // Register sets
  logic [7:0] ctrl_a;  // Set A control byte
  logic [7:0] ctrl_b;  // Set B control byte
  logic       done_a_w;
  logic       done_b_w;

  xfer_ctrl_set #(.ADDR(`CTRL_A_ADDR)) set_a (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_en),
    .addr    (addr),
    .wdata   (wdata),
    .done    (done_a_w),
    .ctrl    (ctrl_a)
  );

  xfer_ctrl_set #(.ADDR(`CTRL_B_ADDR)) set_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_en),
    .addr    (addr),
    .wdata   (wdata),
    .done    (done_b_w),
    .ctrl    (ctrl_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Speed bits and extended mode flag
  logic [7:0] ctrl1_reg;   // Control register 1 copy
  logic [7:0] ctrl1_next;
  logic [7:0] ctrl2_reg;   // Control register 2 copy
  logic [7:0] ctrl2_next;
  logic       ext_reg;     // Extended mode latched by any 0Fh write
  logic       ext_next;

  // Capture writes to the other control registers
  always_comb begin
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    ext_next   = ext_reg;
    if (wr_en && (addr == `CTRL1_ADDR)) begin
      ctrl1_next = wdata;
    end
    if (wr_en && (addr == `CTRL2_ADDR)) begin
      ctrl2_next = wdata;
      ext_next   = 1'b1;
    end
  end

  // Register the speed configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl1_reg <= `CTRL1_RESET;
      ctrl2_reg <= `CTRL2_RESET;
      ext_reg   <= 1'b0;
    end else begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      ext_reg   <= ext_next;
    end
  end

  // Direct low speed: engine slow and low speed polarity together
  logic direct_ls;
  assign direct_ls = ctrl1_reg[`BIT_LOW_SPEED] & ctrl2_reg[`BIT_LS_POLARITY];
  assign ext_mode  = ext_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Readiness of each set
  logic ready_a;  // Set A armed and enabled
  logic ready_b;  // Set B armed, enabled and usable
  assign ready_a = ctrl_a[`BIT_ENABLE] & ctrl_a[`BIT_GO];
  assign ready_b = ctrl_b[`BIT_ENABLE] & ctrl_b[`BIT_GO] & ext_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Scheduler
  host_xfer_pkg::sched_state_t state_reg;
  host_xfer_pkg::sched_state_t state_next;
  logic cur_b_reg;    // Set currently selected
  logic cur_b_next;
  logic pref_b_reg;   // Set preferred on next pick
  logic pref_b_next;
  logic launch_next;
  logic pick_b;       // Set chosen this cycle
  logic pick_ok;      // A set is ready to be chosen
  logic [7:0] pick_ctrl;

  // Preference alternates so a completed set hands over to the other
  always_comb begin
    pick_b  = 1'b0;
    pick_ok = 1'b0;
    if (pref_b_reg && ready_b) begin
      pick_b  = 1'b1;
      pick_ok = 1'b1;
    end else if (ready_a) begin
      pick_b  = 1'b0;
      pick_ok = 1'b1;
    end else if (ready_b) begin
      pick_b  = 1'b1;
      pick_ok = 1'b1;
    end
    pick_ctrl = pick_b ? ctrl_b : ctrl_a;
  end

  // Next scheduler state
  always_comb begin
    state_next  = state_reg;
    cur_b_next  = cur_b_reg;
    pref_b_next = pref_b_reg;
    launch_next = 1'b0;
    done_a_w    = 1'b0;
    done_b_w    = 1'b0;
    case (state_reg)
      host_xfer_pkg::SCH_IDLE: begin
        if (pick_ok) begin
          cur_b_next = pick_b;
          // Aligned packets wait for an SOF; others go when engine free
          if (pick_ctrl[`BIT_ALIGN]) begin
            state_next = host_xfer_pkg::SCH_WAIT_SOF;
          end else if (!engine_busy) begin
            state_next = host_xfer_pkg::SCH_LAUNCH;
          end
        end
      end
      host_xfer_pkg::SCH_WAIT_SOF: begin
        // Dropping enable or go cancels the held packet
        if (!(cur_b_reg ? ready_b : ready_a)) begin
          state_next = host_xfer_pkg::SCH_IDLE;
        end else if (sof_sent) begin
          state_next = host_xfer_pkg::SCH_LAUNCH;
        end
      end
      host_xfer_pkg::SCH_LAUNCH: begin
        // Recheck readiness so a late disable still blocks launch
        if (cur_b_reg ? ready_b : ready_a) begin
          if (!engine_busy) begin
            launch_next = 1'b1;
            state_next  = host_xfer_pkg::SCH_BUSY;
          end
        end else begin
          state_next = host_xfer_pkg::SCH_IDLE;
        end
      end
      host_xfer_pkg::SCH_BUSY: begin
        if (xfer_complete) begin
          done_a_w    = !cur_b_reg;
          done_b_w    = cur_b_reg;
          pref_b_next = !cur_b_reg;
          state_next  = host_xfer_pkg::SCH_IDLE;
        end
      end
      default: begin
        state_next = host_xfer_pkg::SCH_IDLE;
      end
    endcase
  end

  // Register scheduler state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg  <= host_xfer_pkg::SCH_IDLE;
      cur_b_reg  <= 1'b0;
      pref_b_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cur_b_reg  <= cur_b_next;
      pref_b_reg <= pref_b_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet attributes, registered at launch and held during the transfer
  logic [7:0] cur_ctrl;
  logic       launch_reg;
  logic       set_b_reg;
  logic       set_b_next;
  logic       pre_reg;
  logic       pre_next;
  logic       dir_reg;
  logic       dir_next;
  logic       tog_reg;
  logic       tog_next;
  logic       iso_reg;
  logic       iso_next;
  logic       done_a_reg;
  logic       done_b_reg;

  assign cur_ctrl = cur_b_reg ? ctrl_b : ctrl_a;

  // Decode the selected set's byte when the launch fires
  always_comb begin
    set_b_next = set_b_reg;
    pre_next   = pre_reg;
    dir_next   = dir_reg;
    tog_next   = tog_reg;
    iso_next   = iso_reg;
    if (launch_next) begin
      set_b_next = cur_b_reg;
      // Preamble only toward hub low speed; direct mode ignores it
      pre_next   = cur_ctrl[`BIT_PREAMBLE] & ~direct_ls;
      dir_next   = cur_ctrl[`BIT_DIR];
      // Toggle has meaning only on OUT; IN packets report DATA0
      tog_next   = cur_ctrl[`BIT_TOGGLE] & cur_ctrl[`BIT_DIR];
      iso_next   = cur_ctrl[`BIT_ISO];
    end
  end

  // Register outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      launch_reg <= 1'b0;
      set_b_reg  <= 1'b0;
      pre_reg    <= 1'b0;
      dir_reg    <= 1'b0;
      tog_reg    <= 1'b0;
      iso_reg    <= 1'b0;
      done_a_reg <= 1'b0;
      done_b_reg <= 1'b0;
    end else begin
      launch_reg <= launch_next;
      set_b_reg  <= set_b_next;
      pre_reg    <= pre_next;
      dir_reg    <= dir_next;
      tog_reg    <= tog_next;
      iso_reg    <= iso_next;
      done_a_reg <= done_a_w;
      done_b_reg <= done_b_w;
    end
  end

  assign launch        = launch_reg;
  assign launch_set_b  = set_b_reg;
  assign send_preamble = pre_reg;
  assign dir_out       = dir_reg;
  assign data_toggle   = tog_reg;
  assign iso_mode      = iso_reg;
  assign done_a        = done_a_reg;
  assign done_b        = done_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: control bytes of both sets, others read zero here
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Address decode for reads
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_en) begin
      if (addr == `CTRL_A_ADDR) begin
        rdata_next = ctrl_a;
      end else if (addr == `CTRL_B_ADDR) begin
        rdata_next = ctrl_b;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // Register read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
endmodule : usb_host_transfer_control

/* File: bench/xfer_ctrl_assertions.sv */
`timescale 1ns/1ps
// Watches the transfer control ports; one clock domain, async reset
module xfer_ctrl_checker (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] rdata,
  input wire logic       engine_busy,
  input wire logic       xfer_complete,
  input wire logic       launch,
  input wire logic       launch_set_b,
  input wire logic       send_preamble,
  input wire logic       dir_out,
  input wire logic       data_toggle,
  input wire logic       iso_mode,
  input wire logic       done_a,
  input wire logic       done_b,
  input wire logic       ext_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Toggle only ever reaches the wire on OUT packets
  property p_toggle_out; data_toggle |-> dir_out; endproperty
  a_toggle_out: assert property (p_toggle_out) else $error("toggle set on IN");
  // Every completion raises exactly one done pulse a cycle later
  property p_done_follow; xfer_complete |=> (done_a ^ done_b); endproperty
  a_done_follow: assert property (p_done_follow) else $error("done missing");
  // A done pulse needs a completion behind it
  property p_done_cause; (done_a || done_b) |-> $past(xfer_complete); endproperty
  a_done_cause: assert property (p_done_cause) else $error("stray done");
  // A done pulse names the set that was launched last
  property p_done_set; (done_a || done_b) |-> (done_b == launch_set_b); endproperty
  a_done_set: assert property (p_done_set) else $error("done on wrong set");
  // Launch is a single-cycle strobe
  property p_launch_pulse; launch |=> !launch; endproperty
  a_launch_pulse: assert property (p_launch_pulse) else $error("launch too long");
  // Never launch onto an occupied engine
  property p_launch_free; launch |-> !$past(engine_busy); endproperty
  a_launch_free: assert property (p_launch_free) else $error("launch while busy");
  // Set B stays dead until extended mode is on
  property p_b_ext; (launch && launch_set_b) |-> ext_mode; endproperty
  a_b_ext: assert property (p_b_ext) else $error("set B without ext mode");
  // Any write to the second control register turns extended mode on
  property p_ext_set; (wr_en && addr == 8'h0f) |=> ext_mode; endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext mode not set");
  // Extended mode is sticky until reset
  property p_ext_hold; ext_mode |=> ext_mode; endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("ext mode dropped");
  // Reserved bit reads back zero from either set
  property p_reserved; (rd_en && (addr == 8'h00 || addr == 8'h08)) |=> !rdata[3]; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  // Packet attributes only move together with a launch
  property p_attr_hold;
    !launch |-> $stable({send_preamble, dir_out, data_toggle, iso_mode});
  endproperty
  a_attr_hold: assert property (p_attr_hold) else $error("attributes moved");
  c_launch_b: cover property (launch && launch_set_b);
  c_pre: cover property (launch && send_preamble);
  c_done_a: cover property (done_a);
endmodule : xfer_ctrl_checker
bind usb_host_transfer_control xfer_ctrl_checker chk_u (
  .clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .rdata(rdata),
  .engine_busy(engine_busy), .xfer_complete(xfer_complete), .launch(launch),
  .launch_set_b(launch_set_b), .send_preamble(send_preamble), .dir_out(dir_out),
  .data_toggle(data_toggle), .iso_mode(iso_mode), .done_a(done_a), .done_b(done_b),
  .ext_mode(ext_mode));

/* File: bench/engine_model.sv */
`timescale 1ns/1ps
// Serial engine stand-in: busy for a chosen time per packet, SOF on request
module engine_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       launch,
  input  wire logic       sof_req,
  input  wire logic [3:0] busy_len,
  output logic            sof_sent,
  output logic            engine_busy,
  output logic            xfer_complete
);
  logic [3:0] cnt_reg;  // Remaining busy cycles
  // Busy from launch to completion; long lengths model slow devices
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg       <= 4'h0;
      sof_sent      <= 1'b0;
      engine_busy   <= 1'b0;
      xfer_complete <= 1'b0;
    end else begin
      sof_sent      <= sof_req;
      xfer_complete <= 1'b0;
      if (launch) begin
        engine_busy <= 1'b1;
        cnt_reg     <= busy_len;
      end else if (engine_busy && cnt_reg == 4'h0) begin
        engine_busy   <= 1'b0;
        xfer_complete <= 1'b1;
      end else if (engine_busy) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : engine_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, sof_req = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [3:0] busy_len = 4'h2;
  logic [7:0] rdata;
  logic       sof_sent, engine_busy, xfer_complete, launch, launch_set_b;
  logic       send_preamble, dir_out, data_toggle, iso_mode, done_a, done_b, ext_mode;
  int         n_fail = 0, num_checks = 0, n_launch = 0, n_done = 0, cycles = 0;
  logic [7:0] exp_q[$];  // Expected launch attributes, oldest first
  always #50 clk = ~clk;
  usb_host_transfer_control dut_u (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .sof_sent(sof_sent),
    .engine_busy(engine_busy), .xfer_complete(xfer_complete), .launch(launch),
    .launch_set_b(launch_set_b), .send_preamble(send_preamble), .dir_out(dir_out),
    .data_toggle(data_toggle), .iso_mode(iso_mode), .done_a(done_a), .done_b(done_b),
    .ext_mode(ext_mode));
  engine_model eng_u (.clk(clk), .sys_rst(sys_rst), .launch(launch), .sof_req(sof_req),
    .busy_len(busy_len), .sof_sent(sof_sent), .engine_busy(engine_busy),
    .xfer_complete(xfer_complete));
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read, then compare once the registered data has landed
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1 check(rdata, exp);
  endtask : rd
  // Note what the launch must carry, then program the set
  task arm(input logic b, input logic [7:0] c, input logic pre);
    exp_q.push_back({3'h0, b, pre, c[2], c[6] & c[2], c[4]});
    wr(b ? 8'h08 : 8'h00, c);
  endtask : arm
  task wait_idle;
    int i;
    // Launch still high covers the edge where the note is popped before busy rises
    for (i = 0; i < 300 && (exp_q.size() != 0 || engine_busy !== 1'b0 || launch === 1'b1);
         i++) @(posedge clk);
    // A drain that never finishes counts against the run
    if (i >= 300) check(8'hff, 8'h00);
    repeat (3) @(posedge clk);
  endtask : wait_idle
  // Launch monitor: each launch takes the oldest note; also the hang limit
  always @(posedge clk) begin
    cycles++;
    if (launch === 1'b1) begin
      n_launch++;
      if (exp_q.size() == 0) check(8'hff, 8'h00);
      else check({3'h0, launch_set_b, send_preamble, dir_out, data_toggle, iso_mode},
                 exp_q.pop_front());
    end
    if (done_a === 1'b1 || done_b === 1'b1) n_done++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    int i;
    int l0;
    logic [7:0] c;
    void'($urandom(27335));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h08, 8'h00);
    // Set B armed early waits for extended mode
    wr(8'h08, 8'h03);
    repeat (10) @(posedge clk);
    check(8'(n_launch), 8'h00);
    exp_q.push_back(8'h10);
    wr(8'h0f, 8'h00);
    wait_idle;
    rd(8'h08, 8'h02);
    // Random packets on set A, alignment off, random engine delay
    for (i = 0; i < 6; i++) begin
      c = (8'($urandom) & 8'hdf) | 8'h03;
      busy_len <= 4'($urandom);
      arm(1'b0, c, c[7]);
      wait_idle;
      rd(8'h00, c & 8'hf6);
    end
    // Direct low speed ignores the preamble bit
    wr(8'h05, 8'h20);
    wr(8'h0f, 8'h40);
    arm(1'b0, 8'h87, 1'b0);
    wait_idle;
    wr(8'h05, 8'h00);
    wr(8'h0f, 8'h00);
    // Aligned packet waits for the next SOF
    l0 = n_launch;
    arm(1'b0, 8'h23, 1'b0);
    repeat (10) @(posedge clk);
    check(8'(n_launch - l0), 8'h00);
    sof_req <= 1'b1;
    @(posedge clk);
    sof_req <= 1'b0;
    wait_idle;
    check(8'(n_launch - l0), 8'h01);
    // Go without enable does nothing
    l0 = n_launch;
    wr(8'h00, 8'h01);
    repeat (10) @(posedge clk);
    check(8'(n_launch - l0), 8'h00);
    wr(8'h00, 8'h00);
    // Overlap: A armed while B is on the wire follows on completion
    l0 = n_done;
    busy_len <= 4'hf;
    arm(1'b1, 8'h07, 1'b0);
    arm(1'b0, 8'h53, 1'b0);
    wait_idle;
    check(8'(n_done - l0), 8'h02);
    complete_run();
  end
endmodule : testbench
